/* File: tb/reset_cause_status_assertions.sv */
// checker for the reset cause register block
module reset_cause_checker (
  input logic ref_clk,
  input logic resetn,
  input logic [11:0] addr,
  input logic [7:0] wdata,
  input logic wr_en,
  input logic rd_en,
  input logic [7:0] rdata,
  input logic ev_power_on,
  input logic ev_pin_reset,
  input logic ev_wdt_run,
  input logic ev_debugger,
  input logic ev_debug_pin,
  input logic ev_gpio_wake,
  input logic ev_wdt_wake,
  input logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [6:0] ev = {ev_wdt_wake, ev_gpio_wake, ev_debug_pin, ev_debugger, ev_wdt_run, ev_pin_reset, ev_power_on};
  wire rd = rd_en && addr == 12'hFF0;
  wire quiet = ~|ev;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  function automatic logic oth(int i, logic [6:0] e);
    return |(e & ~(7'h01 << i));
  endfunction
  // a lone event then a read shows exactly its row
  property row(int i, logic [7:0] v);
    quiet[*3] ##1 ($rose(ev[i]) && !oth(i, ev)) ##1 (!oth(i, ev))[*3] ##1 (rd && !oth(i, ev)) |=> rdata == v;
  endproperty
  a_row_power_on: assert property (row(0, 8'h80)) else $error("power-on row wrong");
  a_row_pin: assert property (row(1, 8'h10)) else $error("pin reset row wrong");
  a_row_wdt_run: assert property (row(2, 8'h20)) else $error("watchdog row wrong");
  a_row_debugger: assert property (row(3, 8'h80)) else $error("debugger row wrong");
  a_row_debug_pin: assert property (row(4, 8'h80)) else $error("debug pin row wrong");
  a_row_gpio: assert property (row(5, 8'h40)) else $error("gpio wake row wrong");
  a_row_wdt_wake: assert property (row(6, 8'h60)) else $error("watchdog wake row wrong");
  a_read_clears: assert property (quiet[*5] ##0 rd ##1 (rd && quiet) |=> rdata == 8'h00) else $error("read did not clear");
  a_reserved_zero: assert property ($past(rd) |-> rdata[3:0] == 4'h0) else $error("reserved bits set");
  // wake pulse reaches the flag three edges after the rise, beside the read
  a_set_beats_read: assert property (($rose(ev[5]) && !oth(5, ev)) ##1 !oth(5, ev) ##1 (rd && !oth(5, ev)) ##2
    (rd && !oth(5, ev)) |=> rdata == 8'h40) else $error("read lost a same-cycle cause");
  a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00) else $error("rdata outside read");
  cover property (rd ##1 rdata == 8'h60);
  cover property (rd ##1 rd);
  cover property ($rose(irq));
endmodule
bind reset_cause_status reset_cause_checker chk_i (.ref_clk(ref_clk), .resetn(resetn), .addr(addr),
  .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .ev_power_on(ev_power_on),
  .ev_pin_reset(ev_pin_reset), .ev_wdt_run(ev_wdt_run), .ev_debugger(ev_debugger),
  .ev_debug_pin(ev_debug_pin), .ev_gpio_wake(ev_gpio_wake), .ev_wdt_wake(ev_wdt_wake), .irq(irq));

/* File: tb/reset_cause_status_tb.sv */
// self-checking bench for the reset cause register block
module reset_cause_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, resetn, wr_en, rd_en, irq;
  logic [11:0] addr;
  logic [7:0] wdata, rdata;
  logic [6:0] ev;
  logic [7:0] cause = 8'h80, ist = 8'h00, msk = 8'h00;
  int fails = 0, checks = 0, cyc = 0, n;
  localparam logic [7:0] row [7] = '{8'h80, 8'h10, 8'h20, 8'h80, 8'h80, 8'h40, 8'h60};
  reset_cause_status dut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
    .rd_en(rd_en), .rdata(rdata), .ev_power_on(ev[0]), .ev_pin_reset(ev[1]), .ev_wdt_run(ev[2]),
    .ev_debugger(ev[3]), .ev_debug_pin(ev[4]), .ev_gpio_wake(ev[5]), .ev_wdt_wake(ev[6]), .irq(irq));
  ////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function logic [7:0] mread(input logic [11:0] a);
    mread = a == 12'hFF0 ? cause : a == 12'hFF4 ? ist : a == 12'hFF8 ? msk : 8'h00;
    if (a == 12'hFF0) cause = 8'h00;
  endfunction
  // k back-to-back reads of one address
  task rd(input logic [11:0] a, input int k);
    @(posedge ref_clk);
    rd_en <= 1;
    addr <= a;
    for (int j = 0; j < k; j++) begin
      @(posedge ref_clk);
      if (j == k - 1) rd_en <= 0;
      #1 chk(rdata, mread(a));
      chk({7'h00, irq}, {7'h00, |(ist & msk)});
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en <= 1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr_en <= 0;
    if (a == 12'hFF4) ist = ist & ~d;
    if (a == 12'hFF8) msk = d & 8'hF0;
  endtask
  // event lands three edges after its rise, read on the fourth
  task ev_go(input int i);
    @(posedge ref_clk);
    ev[i] <= 1;
    repeat (3) @(posedge ref_clk);
    ist = ist | (row[i] & ~cause);
    cause = row[i];
    rd(12'hFF0, 1);
    @(posedge ref_clk);
    ev[i] <= 0;
    repeat (4) @(posedge ref_clk);
  endtask
  task stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
  initial begin
    resetn = 0;
    addr = 0;
    wdata = 0;
    wr_en = 0;
    rd_en = 0;
    ev = 0;
    void'($urandom(32'h441C));
    repeat (16) @(posedge ref_clk);
    resetn <= 1;
    rd(12'hFF0, 2);
    $display("test reset value done");
    // reserved bits written as zero only
    wr(12'hFF0, 8'hF0);
    rd(12'hFF0, 1);
    $display("test write ignored done");
    for (n = 0; n < 21; n++) begin
      wr(12'hFF8, 8'($urandom));
      ev_go(n % 7);
      rd(12'hFF4, 1);
      wr(12'hFF4, 8'($urandom));
      rd(12'($urandom_range(4095)), 1);
    end
    $display("test event table done");
    // wake lands on the same edge as a read of the cause register
    @(posedge ref_clk);
    ev[5] <= 1;
    @(posedge ref_clk);
    ist = ist | (8'h40 & ~cause);
    rd(12'hFF0, 1);
    cause = 8'h40;
    rd(12'hFF0, 1);
    @(posedge ref_clk);
    ev[5] <= 0;
    $display("test set beats read done");
    stop_test;
  end
endmodule

/* File: verilog/event_pulse.v */
// turns a synchronised level into a one-cycle rising-edge pulse
module event_pulse (
  input wire ref_clk,
  input wire resetn,
  input wire level,
  output wire pulse
);
  reg last;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      last <= 1'b0;
    end else begin
      last <= level;
    end
  end

  assign pulse = level & ~last;
endmodule

/* File: verilog/reset_cause_defines.vh */
// offsets, field positions, reset values and encodings for the reset cause block
`ifndef RESET_CAUSE_DEFINES_VH
`define RESET_CAUSE_DEFINES_VH

`define ADDR_W 12
`define OFF_RESET_CAUSE 12'hFF0
`define OFF_IRQ_STATUS 12'hFF4
`define OFF_IRQ_MASK 12'hFF8

`define BIT_POWER_ON 7
`define BIT_LOW_POWER 6
`define BIT_WATCHDOG 5
`define BIT_PIN_RESET 4

`define EVT_POWER_ON 0
`define EVT_PIN_RESET 1
`define EVT_WDT_RUN 2
`define EVT_DEBUGGER 3
`define EVT_DEBUG_PIN 4
`define EVT_GPIO_WAKE 5
`define EVT_WDT_WAKE 6
`define EVT_N 7

`define IRQ_RESET_VAL 8'h00
`define MASK_RESET_VAL 8'h00
`define CAUSE_POR_VAL 8'h80
`define FLAG_MASK 8'hF0

`endif

/* File: verilog/reset_cause_status.v */
// reset cause status register with event inputs, register port and interrupt
`include "reset_cause_defines.vh"

////////////////////////////////////////////////////////////////
// Operation
// [RULE1] power-on reset sets power_on_flag.
// [RULE2] watchdog time-out or stop-mode recovery clears power_on_flag.
// [RULE3] reading the register clears power_on_flag.
// [RULE4] every stop-mode recovery sets low_power_recovery_flag.
// [RULE5] watchdog wake sets both flags; other wakes leave watchdog flag zero.
// [RULE6] power-on or running watchdog time-out clears low_power_recovery_flag.
// [RULE7] reading the register clears low_power_recovery_flag.
// [RULE8] any watchdog time-out sets watchdog_timeout_flag.
// [RULE9] power-on or input-pin wake clears watchdog_timeout_flag.
// [RULE10] reading the register clears watchdog_timeout_flag.
// [RULE11] software reads the register before clearing the watchdog interrupt.
// [RULE12] external reset pin assertion sets pin_reset_flag.
// [RULE13] power-on, input-pin wake or register read clears pin_reset_flag.
// [RULE14] bits three to zero read zero; software writes zeros there.
// [RULE15] debugger or debug_pin reset sets only power_on_flag.
// [RULE16] input-pin wake sets only low_power_recovery_flag.
// [RULE17] a setting event wins over a clearing read in one cycle.
// [RULE18] writes to the reset cause register are ignored.
module reset_cause_status (
  input wire ref_clk,
  input wire resetn,
  input wire [11:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire ev_power_on,
  input wire ev_pin_reset,
  input wire ev_wdt_run,
  input wire ev_debugger,
  input wire ev_debug_pin,
  input wire ev_gpio_wake,
  input wire ev_wdt_wake,
  output wire irq
);

  ////////////////////////////////////////////////////////////////
  // event inputs come from the reset and recovery logic, maybe other clocks

  wire [`EVT_N-1:0] ev_raw;
  wire [`EVT_N-1:0] ev_sync;
  wire [`EVT_N-1:0] ev;

  assign ev_raw = {ev_wdt_wake, ev_gpio_wake, ev_debug_pin, ev_debugger,
                   ev_wdt_run, ev_pin_reset, ev_power_on};

  genvar gi;
  generate
    for (gi = 0; gi < `EVT_N; gi = gi + 1) begin : g_evt
      sync2 u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .d(ev_raw[gi]),
        .q(ev_sync[gi])
      );
      event_pulse u_pulse (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .level(ev_sync[gi]),
        .pulse(ev[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // event classes; several sources share one row of the cause table

  wire por_hit;
  wire pin_hit;
  wire wdt_run_hit;
  wire wdt_wake_hit;
  wire gpio_hit;
  wire wdt_hit;
  wire stop_hit;
  wire any_set;

  // [RULE15] debugger and debug_pin act as power-on
  assign por_hit = ev[`EVT_POWER_ON] | ev[`EVT_DEBUGGER] | ev[`EVT_DEBUG_PIN];
  assign pin_hit = ev[`EVT_PIN_RESET];
  assign wdt_run_hit = ev[`EVT_WDT_RUN];
  assign wdt_wake_hit = ev[`EVT_WDT_WAKE];
  assign gpio_hit = ev[`EVT_GPIO_WAKE];
  assign wdt_hit = wdt_run_hit | wdt_wake_hit;
  assign stop_hit = gpio_hit | wdt_wake_hit;
  // any event rewrites the whole row, so all four flags drop first
  assign any_set = |ev;

  ////////////////////////////////////////////////////////////////
  // address decode

  wire sel_cause;
  wire sel_status;
  wire sel_mask;
  wire rd_cause;
  wire wr_status;
  wire wr_mask;

  assign sel_cause = (addr == `OFF_RESET_CAUSE);
  assign sel_status = (addr == `OFF_IRQ_STATUS);
  assign sel_mask = (addr == `OFF_IRQ_MASK);
  assign rd_cause = rd_en & sel_cause;
  assign wr_status = wr_en & sel_status;
  assign wr_mask = wr_en & sel_mask;

  ////////////////////////////////////////////////////////////////
  // flag update; events are applied after the read clear

  localparam [7:0] CAUSE_RST = `CAUSE_POR_VAL;

  reg power_on_flag;
  reg low_power_recovery_flag;
  reg watchdog_timeout_flag;
  reg pin_reset_flag;
  reg next_power_on_flag;
  reg next_low_power_recovery_flag;
  reg next_watchdog_timeout_flag;
  reg next_pin_reset_flag;

  // [RULE1] [RULE2] [RULE3] power-on flag
  always @* begin
    next_power_on_flag = power_on_flag;
    if (rd_cause) begin
      next_power_on_flag = 1'b0;
    end
    // [RULE17] set beats read, so no cause is lost
    if (any_set) begin
      next_power_on_flag = por_hit;
    end
  end

  // [RULE4] [RULE6] [RULE7] stop recovery flag
  always @* begin
    next_low_power_recovery_flag = low_power_recovery_flag;
    if (rd_cause) begin
      next_low_power_recovery_flag = 1'b0;
    end
    // [RULE16] any wake source
    if (any_set) begin
      next_low_power_recovery_flag = stop_hit;
    end
  end

  // [RULE8] [RULE9] [RULE10] watchdog flag
  always @* begin
    next_watchdog_timeout_flag = watchdog_timeout_flag;
    if (rd_cause) begin
      next_watchdog_timeout_flag = 1'b0;
    end
    // [RULE5] watchdog wake sets both flags
    if (any_set) begin
      next_watchdog_timeout_flag = wdt_hit;
    end
  end

  // [RULE12] [RULE13] pin reset flag
  always @* begin
    next_pin_reset_flag = pin_reset_flag;
    if (rd_cause) begin
      next_pin_reset_flag = 1'b0;
    end
    if (any_set) begin
      next_pin_reset_flag = pin_hit;
    end
  end

  // releasing resetn counts as a power-on reset
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      power_on_flag <= CAUSE_RST[`BIT_POWER_ON];
    end else begin
      power_on_flag <= next_power_on_flag;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      low_power_recovery_flag <= CAUSE_RST[`BIT_LOW_POWER];
    end else begin
      low_power_recovery_flag <= next_low_power_recovery_flag;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      watchdog_timeout_flag <= CAUSE_RST[`BIT_WATCHDOG];
    end else begin
      watchdog_timeout_flag <= next_watchdog_timeout_flag;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_reset_flag <= CAUSE_RST[`BIT_PIN_RESET];
    end else begin
      pin_reset_flag <= next_pin_reset_flag;
    end
  end

  reg [7:0] cause_value;
  // [RULE14] reserved reads zero
  always @* begin
    cause_value = 8'h00;
    cause_value[`BIT_POWER_ON] = power_on_flag;
    cause_value[`BIT_LOW_POWER] = low_power_recovery_flag;
    cause_value[`BIT_WATCHDOG] = watchdog_timeout_flag;
    cause_value[`BIT_PIN_RESET] = pin_reset_flag;
  end

  ////////////////////////////////////////////////////////////////
  // interrupt status and mask, same layout as the cause register

  reg [7:0] irq_status;
  reg [7:0] irq_mask;
  reg [7:0] next_irq_status;
  reg [7:0] next_irq_mask;
  reg [7:0] new_flags;
  wire [7:0] set_bits;

  // next flag values in the cause layout
  always @* begin
    new_flags = 8'h00;
    new_flags[`BIT_POWER_ON] = next_power_on_flag;
    new_flags[`BIT_LOW_POWER] = next_low_power_recovery_flag;
    new_flags[`BIT_WATCHDOG] = next_watchdog_timeout_flag;
    new_flags[`BIT_PIN_RESET] = next_pin_reset_flag;
  end

  // a flag rising is the event reported; a flag already up reports nothing
  assign set_bits = new_flags & ~cause_value;

  // set wins over a same-cycle write-one-to-clear
  always @* begin
    next_irq_status = irq_status;
    if (wr_status) begin
      next_irq_status = irq_status & ~wdata;
    end
    next_irq_status = (next_irq_status | set_bits) & `FLAG_MASK;
  end

  always @* begin
    next_irq_mask = irq_mask;
    if (wr_mask) begin
      next_irq_mask = wdata & `FLAG_MASK;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_status <= `IRQ_RESET_VAL;
      irq_mask <= `MASK_RESET_VAL;
    end else begin
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////
  // read port; writes to the cause register fall through unused

  reg [7:0] next_rdata;

  // [RULE18] cause register not writable
  // data stand one cycle only, so idle cycles read back zero
  always @* begin
    next_rdata = 8'h00;
    if (rd_en) begin
      case (addr)
        `OFF_RESET_CAUSE: begin
          next_rdata = cause_value;
        end
        `OFF_IRQ_STATUS: begin
          next_rdata = irq_status;
        end
        `OFF_IRQ_MASK: begin
          next_rdata = irq_mask;
        end
        default: begin
          next_rdata = 8'h00;
        end
      endcase
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

/* File: verilog/sync2.v */
// two-flop synchroniser for one level
module sync2 (
  input wire ref_clk,
  input wire resetn,
  input wire d,
  output reg q
);
  reg meta;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
